// [osf_fault_core.sv]
// top: fault detection, latching and status for an octal low side switch
// Notes on behaviour
// - four fault kinds reported; overvoltage global, others per channel.
// - over-temperature switches only that channel off at once.
// - heat shutdown stays off until next write commands the channel on.
// - overvoltage forces all off until cleared and a new word written.
// - status after an overvoltage event reads all ones.
// - open load flagged only for channels commanded off with drain low.
// - select rising edge starts delay window; comparators ignored meanwhile.
// - open load does not latch; status recovers when drain rises.
// - drain above threshold on a commanded-on channel is a short.
// - select rising turns on commanded channels and starts the window.
// - latch mode: short shuts channel at window end or within 20 us.
// - latch disable high: shorts never switch a channel off.
// - short shutdown per channel; heat and overvoltage ignore the strap.
// - command bit zero turns on; status equals command when healthy.
// - select fall loads status and enables output; rise applies command.
// - words shift msb first, channel seven first, channel zero last.
// - latched short stays off until next write; each write retries it.
`timescale 1ns/10ps
`default_nettype none

module osf_fault_core
    import osf_pkg::*;
(
    // core clock and reset
    input  wire logic      CLOCK,
    input  wire logic      NRST,
    // serial link
    input  wire logic      LINK_CLK,
    input  wire logic      SELECT_LOW_N,
    input  wire logic      SDI,
    output logic           SDO,
    output logic           SDO_OE,
    // mode strap
    input  wire logic      SHORT_LATCH_DISABLE,
    // analog detector outputs
    input  wire osf_word_t OVER_TEMP,
    input  wire logic      LOAD_SUPPLY_OV,
    input  wire osf_word_t DRAIN_ABOVE_THRESHOLD,
    // gate drive, 1 = channel on
    output osf_word_t      OUT_ON
);

    osf_core_s  r;
    osf_core_s  n;
    osf_sense_s sense_in;
    osf_word_t  rx_word;
    osf_word_t  ol;
    osf_word_t  status;
    logic       cs_rise;
    logic       cs_fall;
    logic       armed;

    // -------------------------------------------------------------
    // link engine on its own clock
    // -------------------------------------------------------------
    osf_serial_link u_link (
        .link_clk    (LINK_CLK),
        .nrst        (NRST),
        .sel_n       (SELECT_LOW_N),
        .sdi         (SDI),
        .sdo         (SDO),
        .sdo_oe      (SDO_OE),
        .status_word (r.snap),
        .rx_word     (rx_word)
    );

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // spread one enable across all eight channels
    function automatic osf_word_t fill_word(input logic bit_in);
        fill_word = {OSF_CHANNELS{bit_in}};
    endfunction : fill_word

    // pins gathered for the synchroniser
    assign sense_in = '{sel_n: SELECT_LOW_N,
                        sld:   SHORT_LATCH_DISABLE,
                        ov:    LOAD_SUPPLY_OV,
                        ot:    OVER_TEMP,
                        dh:    DRAIN_ABOVE_THRESHOLD};

    // -------------------------------------------------------------
    // derived terms, all from second sync stage
    // -------------------------------------------------------------
    assign cs_rise = r.s2.sel_n & ~r.sel_d;
    assign cs_fall = ~r.s2.sel_n & r.sel_d;
    assign armed   = r.tmr_done & ~cs_rise;
    // open load: commanded off, drain low, window over
    assign ol      = r.cmd & ~r.s2.dh & fill_word(r.tmr_done);
    // status: 1 means off, open load inverts an off bit
    assign status  = r.ov_seen ? OSF_STATUS_OV :
                     (~r.drive ^ ol);

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb
    begin
        n       = r;
        n.s1    = sense_in;
        n.s2    = r.s1;
        n.sel_d = r.s2.sel_n;

        // delay timer runs once per write
        if (!r.tmr_done)
        begin
            n.tmr = r.tmr + 12'h001;
            if (r.tmr == OSF_TMR_LAST)
                n.tmr_done = 1'b1;
        end

        // frame end: apply command, restart window, clear latches
        if (cs_rise)
        begin
            n.cmd      = rx_word;
            n.tmr      = OSF_TMR_ZERO;
            n.tmr_done = 1'b0;
            n.sc_lat   = OSF_WORD_ZERO;
            n.ot_lat   = OSF_WORD_ZERO;
            n.ov_lat   = 1'b0;
        end

        // frame start: freeze status for shifting
        if (cs_fall)
        begin
            n.snap    = status;
            n.ov_seen = 1'b0;
        end

        // fault sets come last so a set beats a clear
        n.ot_lat = n.ot_lat | r.s2.ot;
        if (r.s2.ov)
        begin
            n.ov_lat  = 1'b1;
            n.ov_seen = 1'b1;
        end
        // short on a channel commanded on, latch mode only
        n.sc_lat = n.sc_lat | (~r.cmd & r.s2.dh &
                   fill_word(armed & ~r.s2.sld));

        // gate drive from command and latches
        n.drive = ~n.cmd & ~n.ot_lat & ~n.sc_lat &
                  fill_word(~n.ov_lat);
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            r          <= '0;
            r.s1.sel_n <= 1'b1;
            r.s2.sel_n <= 1'b1;
            r.sel_d    <= 1'b1;
            r.cmd      <= OSF_CMD_RESET;
            r.tmr      <= OSF_TMR_ZERO;
            r.snap     <= OSF_CMD_RESET;
        end
        else
        begin
            r <= n;
        end
    end

    assign OUT_ON = r.drive;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);

    chk_heat_off: assert property (
        (r.s2.ot != OSF_WORD_ZERO) |=> ((r.drive & $past(r.s2.ot)) ==
                                        OSF_WORD_ZERO))
        else $error("heated channel still driven");

    chk_heat_hold: assert property (
        (r.ot_lat != OSF_WORD_ZERO && !cs_rise) |=>
        ((r.ot_lat & $past(r.ot_lat)) == $past(r.ot_lat)))
        else $error("heat latch released without a write");

    chk_ov_all_off: assert property (
        r.s2.ov |=> r.ov_lat ##0 (r.drive == OSF_WORD_ZERO) [*2])
        else $error("channel on during overvoltage");

    chk_ov_report: assert property (
        (cs_fall && r.ov_seen) |=> (r.snap == OSF_STATUS_OV))
        else $error("status not all ones after overvoltage");

    chk_open_load: assert property (
        (cs_fall && !r.ov_seen) |=>
        ((r.snap ^ ~$past(r.drive)) ==
         ($past(r.cmd) & ~$past(r.s2.dh) & fill_word($past(r.tmr_done)))))
        else $error("open load status wrong");

    chk_delay_len: assert property (
        $rose(r.tmr_done) |-> ($past(r.tmr) == OSF_TMR_LAST))
        else $error("delay window length wrong");

    chk_window_start: assert property (
        cs_rise |=> (r.tmr == OSF_TMR_ZERO && !r.tmr_done &&
                     r.cmd == $past(rx_word)))
        else $error("write did not restart window");

    chk_short_off: assert property (
        (armed && !r.s2.sld && (~r.cmd & r.s2.dh) != OSF_WORD_ZERO) |=>
        (((r.drive & ~$past(r.cmd) & $past(r.s2.dh)) == OSF_WORD_ZERO) ##1
         ((r.drive & ~$past(r.cmd, 2) & $past(r.s2.dh, 2)) == OSF_WORD_ZERO ||
          $past(cs_rise))))
        else $error("short not shut off");

    chk_no_latch: assert property (
        r.s2.sld |=> ((r.sc_lat & ~$past(r.sc_lat)) == OSF_WORD_ZERO))
        else $error("short latched with latch disabled");

    chk_retry: assert property (
        cs_rise |=> (r.sc_lat == OSF_WORD_ZERO))
        else $error("short latch survived a write");

    // -------------------------------------------------------------
    // checks on latch release and hold
    // -------------------------------------------------------------
    // overvoltage latch only drops on a write
    chk_ov_held: assert property (
        (r.ov_lat && !cs_rise) |=> r.ov_lat)
        else $error("overvoltage latch released without a write");

    // a write after the supply recovers releases the channels
    chk_ov_clear: assert property (
        (cs_rise && !r.s2.ov) |=> !r.ov_lat)
        else $error("overvoltage latch kept after a write");

    // a write keeps only the heat faults still present
    chk_heat_clear: assert property (
        cs_rise |=> (r.ot_lat == $past(r.s2.ot)))
        else $error("heat latch wrong after a write");

    // a latched short stays off until the next write
    chk_short_hold: assert property (
        (r.sc_lat != OSF_WORD_ZERO && !cs_rise) |=>
        ((r.sc_lat & $past(r.sc_lat)) == $past(r.sc_lat)))
        else $error("short latch released without a write");

    // the all ones report waits for the next frame
    chk_ov_pending: assert property (
        (r.ov_seen && !cs_fall) |=> r.ov_seen)
        else $error("overvoltage report lost before a frame");

    // -------------------------------------------------------------
    // checks on the fault delay window
    // -------------------------------------------------------------
    // counter steps by one while the window runs
    chk_window_run: assert property (
        (!r.tmr_done && !cs_rise) |=>
        (r.tmr == $past(r.tmr) + 12'h001))
        else $error("delay counter did not advance");

    // no short is latched inside the window
    chk_fault_masked: assert property (
        !r.tmr_done |=> ((r.sc_lat & ~$past(r.sc_lat)) == OSF_WORD_ZERO))
        else $error("short latched inside the delay window");

    // open load follows the comparator once the window is over
    chk_ol_follow: assert property (
        r.tmr_done |-> (ol == (r.cmd & ~r.s2.dh)))
        else $error("open load flag not following the comparator");

    // -------------------------------------------------------------
    // checks on the words handed across the link
    // -------------------------------------------------------------
    // snapshot only moves at frame start
    chk_snap_frozen: assert property (
        !cs_fall |=> $stable(r.snap))
        else $error("status snapshot moved inside a frame");

    // command only moves at frame end
    chk_cmd_frozen: assert property (
        !cs_rise |=> $stable(r.cmd))
        else $error("command moved without a frame end");

    // a channel commanded off is never driven
    chk_drive_cmd: assert property (
        (r.drive & r.cmd) == OSF_WORD_ZERO)
        else $error("channel driven while commanded off");

    // -------------------------------------------------------------
    // coverage of the main scenarios
    // -------------------------------------------------------------
    // scenarios the bench should reach
    cov_write: cover property (cs_fall ##[1:1000] cs_rise);
    cov_short: cover property ($rose(r.sc_lat[2]));
    cov_heat: cover property ($rose(r.ot_lat[5]));
    cov_ov: cover property ($fell(r.ov_lat));
    cov_open: cover property (cs_fall && ol != OSF_WORD_ZERO);

endmodule : osf_fault_core
`default_nettype wire

// [osf_pkg.sv]
// package: constants and types for the octal switch fault logic
package osf_pkg;

    // -------------------------------------------------------------
    // sizes
    // -------------------------------------------------------------
    localparam int OSF_CHANNELS = 8;

    typedef logic [OSF_CHANNELS-1:0] osf_word_t;

    // -------------------------------------------------------------
    // reset values and forced words
    // -------------------------------------------------------------
    localparam osf_word_t OSF_CMD_RESET  = 8'hFF; // all channels off
    localparam osf_word_t OSF_STATUS_OV  = 8'hFF; // report after overvoltage
    localparam osf_word_t OSF_WORD_ZERO  = 8'h00;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int OSF_CLK_PERIOD_NS  = 8;      // 125 MHz core clock
    localparam int OSF_DELAY_MIN_NS   = 25000;  // fault delay window
    localparam int OSF_DELAY_MAX_NS   = 100000;
    localparam int OSF_SHORT_MAX_NS   = 20000;  // short shut-off bound
    localparam int OSF_ECHO_GAP_NS    = 5000;   // host echo repeat gap
    localparam int OSF_STARTUP_NS     = 100000; // host status repeat gap
    localparam int OSF_DELAY_CYC      =
        (OSF_DELAY_MIN_NS + OSF_CLK_PERIOD_NS - 1) / OSF_CLK_PERIOD_NS;
    localparam int OSF_SHORT_MAX_CYC  = OSF_SHORT_MAX_NS / OSF_CLK_PERIOD_NS;
    localparam int OSF_TMR_W          = 12;
    localparam logic [OSF_TMR_W-1:0] OSF_TMR_LAST =
        OSF_TMR_W'(OSF_DELAY_CYC - 1);
    localparam logic [OSF_TMR_W-1:0] OSF_TMR_ZERO = 12'h000;

    // -------------------------------------------------------------
    // link framing
    // -------------------------------------------------------------
    localparam logic [3:0] OSF_BITS_PER_WORD = 4'h8;
    localparam logic [3:0] OSF_CNT_ZERO      = 4'h0;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic      sel_n;   // frame select, low during a transfer
        logic      sld;     // short latch disable strap
        logic      ov;      // load supply overvoltage
        osf_word_t ot;      // per channel over-temperature
        osf_word_t dh;      // drain above drain_threshold
    } osf_sense_s;

    typedef struct packed {
        osf_sense_s          s1;       // first sync stage
        osf_sense_s          s2;       // second sync stage
        logic                sel_d;    // delayed select for edges
        osf_word_t           cmd;      // command, 0 = on
        osf_word_t           ot_lat;   // heat shutdown latches
        osf_word_t           sc_lat;   // short shutdown latches
        logic                ov_lat;   // global overvoltage off
        logic                ov_seen;  // report all ones next frame
        logic [OSF_TMR_W-1:0] tmr;     // fault delay counter
        logic                tmr_done; // comparators enabled
        osf_word_t           drive;    // gate drive, 1 = on
        osf_word_t           snap;     // status frozen for the frame
    } osf_core_s;

    typedef struct packed {
        logic [3:0] rise_cnt; // shift-out position in the frame
    } osf_tx_s;

    typedef struct packed {
        osf_word_t rx;        // last eight bits shifted in
    } osf_rx_s;

endpackage : osf_pkg

// [osf_serial_link.sv]
// serial shift engine running on the link clock
`timescale 1ns/10ps
`default_nettype none

module osf_serial_link
    import osf_pkg::*;
(
    // link clock and resets
    input  wire logic      link_clk,
    input  wire logic      nrst,
    // link pins
    input  wire logic      sel_n,
    input  wire logic      sdi,
    output logic           sdo,
    output logic           sdo_oe,
    // core side words, each stable while the other side reads it
    input  wire osf_word_t status_word,
    output osf_word_t      rx_word
);

    osf_tx_s   tx_reg;
    osf_tx_s   tx_next;
    osf_rx_s   rx_reg;
    osf_rx_s   rx_next;
    logic      tx_clr;
    osf_word_t tx_shift;

    // position counter cleared whenever the frame is idle
    assign tx_clr = ~nrst | sel_n;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb
    begin
        tx_next = tx_reg;
        rx_next = rx_reg;
        if (tx_reg.rise_cnt != OSF_BITS_PER_WORD)
        begin
            tx_next.rise_cnt = tx_reg.rise_cnt + 4'h1;
        end
        rx_next.rx = {rx_reg.rx[OSF_CHANNELS-2:0], sdi};
    end

    // output data changes on rising link clock
    always_ff @(posedge link_clk or posedge tx_clr)
    begin
        if (tx_clr)
            tx_reg <= '{rise_cnt: OSF_CNT_ZERO};
        else
            tx_reg <= tx_next;
    end

    // input data taken on falling link clock
    always_ff @(negedge link_clk or negedge nrst)
    begin
        if (!nrst)
            rx_reg <= '{rx: OSF_CMD_RESET};
        else
            rx_reg <= rx_next;
    end

    // -------------------------------------------------------------
    // serial output: status msb first, then received bits cascade
    // -------------------------------------------------------------
    assign tx_shift = status_word << tx_reg.rise_cnt[2:0];
    assign sdo      = (tx_reg.rise_cnt == OSF_BITS_PER_WORD) ?
                      rx_reg.rx[OSF_CHANNELS-1] :
                      tx_shift[OSF_CHANNELS-1];
    assign sdo_oe   = ~sel_n;
    assign rx_word  = rx_reg.rx;

endmodule : osf_serial_link
`default_nettype wire

// [osf_host_model.sv]
// host serial master model that frames commands and collects status
`timescale 1ns/10ps
`default_nettype none

module osf_host_model
    import osf_pkg::*;
(
    // link pins driven by the host
    output logic     link_clk,
    output logic     sel_n,
    output logic     sdi,
    // resolved serial return line
    input  wire logic sdo_line
);

    // ---------------------------------------------------------
    // idle state: select high, link clock parked low
    // ---------------------------------------------------------
    initial
    begin
        link_clk = 1'b0;
        sel_n    = 1'b1;
        sdi      = 1'b0;
    end

    // ---------------------------------------------------------
    // one frame: command out and status in, 12 ns link clock
    // ---------------------------------------------------------
    task automatic xfer(input osf_word_t cmd, output osf_word_t st);
        int i;
        st = OSF_WORD_ZERO;
        #3 sel_n = 1'b0;                         // off the core grid
        #50;                                     // wait for snapshot
        for (i = OSF_CHANNELS - 1; i >= 0; i--)
        begin
            #1 sdi = cmd[i];
            st[i] = sdo_line;
            #5 link_clk = 1'b1;
            #6 link_clk = 1'b0;
        end
        #1 sdi = ~sdi;                           // stale data not held
        #20 sel_n = 1'b1;
        #40;                                     // gap before next frame
    endtask : xfer

endmodule : osf_host_model
`default_nettype wire

// [octal_switch_fault_logic_tb_top.sv]
// self-checking bench for the octal switch fault logic
`timescale 1ns/10ps
`default_nettype none

module octal_switch_fault_logic_tb_top
    import osf_pkg::*;
;
    // ---------------------------------------------------------
    // stimulus constants and bench signals
    // ---------------------------------------------------------
    localparam int        LIMIT = 40000;
    localparam osf_word_t CMD   = 8'h5A; // on: channels 7 5 2 0
    localparam osf_word_t ON    = 8'hA5;
    logic      clk;
    logic      nrst;
    logic      lclk;
    logic      sel_n;
    logic      sdi;
    logic      sdo;
    logic      sdo_oe;
    logic      sdo_line;
    logic      sld;
    logic      ov;
    osf_word_t ot;
    osf_word_t drain;
    osf_word_t out_on;
    osf_word_t st;
    int        fail_count = 0;
    int        num_checks = 0;
    int        cycles     = 0;

    // released return line pulled high at the host
    assign sdo_line = sdo_oe ? sdo : 1'b1;

    // core clock, 8 ns
    always #4 clk = ~clk;

    // ---------------------------------------------------------
    // design and host model
    // ---------------------------------------------------------
    osf_fault_core dut_u (
        .CLOCK(clk), .NRST(nrst), .LINK_CLK(lclk),
        .SELECT_LOW_N(sel_n), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe),
        .SHORT_LATCH_DISABLE(sld), .OVER_TEMP(ot),
        .LOAD_SUPPLY_OV(ov), .DRAIN_ABOVE_THRESHOLD(drain),
        .OUT_ON(out_on)
    );

    osf_host_model host_u (
        .link_clk(lclk), .sel_n(sel_n), .sdi(sdi), .sdo_line(sdo_line)
    );

    // ---------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1; // step past the edge so outputs have settled
    endtask : cyc

    task automatic check(input string what, input osf_word_t seen,
                         input osf_word_t exp);
        #1;
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // ---------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------
    task automatic s_startup();
        check("out_on reset", out_on, OSF_WORD_ZERO);
        host_u.xfer(CMD, st);
        check("first status", st, 8'hFF);
        check("select released", {7'h00, sdo_oe}, 8'h00);
        cyc(2);
        check("out_on applied", out_on, ON);
        host_u.xfer(CMD, st);
        check("echo status", st, CMD);
    endtask : s_startup

    task automatic s_open_load();
        @(posedge clk);
        drain <= 8'h58;
        cyc(10);
        host_u.xfer(CMD, st);
        check("open in window", st, CMD);
        cyc(3200);
        host_u.xfer(CMD, st);
        check("open load", st, 8'h58);
        @(posedge clk);
        drain <= CMD;
        cyc(3200);
        host_u.xfer(CMD, st);
        check("open recovered", st, CMD);
    endtask : s_open_load

    task automatic s_short_latch();
        cyc(3200);
        @(posedge clk);
        drain <= CMD | 8'h04;
        cyc(5);
        check("short off", out_on, 8'hA1);
        @(posedge clk);
        drain <= CMD;
        cyc(10);
        check("short held", out_on, 8'hA1);
        host_u.xfer(CMD, st);
        check("short status", st, 8'h5E);
        cyc(2);
        check("short retry", out_on, ON);
        @(posedge clk);
        drain <= CMD | 8'h04;
        host_u.xfer(CMD, st);
        cyc(3000);
        check("in window", out_on, ON);
        cyc(200);
        check("window end", out_on, 8'hA1);
        @(posedge clk);
        drain <= CMD;
    endtask : s_short_latch

    task automatic s_current_limit();
        host_u.xfer(CMD, st);
        @(posedge clk);
        sld <= 1'b1;
        cyc(3200);
        @(posedge clk);
        drain <= CMD | 8'h04;
        cyc(100);
        check("limit stays on", out_on, ON);
        @(posedge clk);
        drain <= CMD;
    endtask : s_current_limit

    task automatic s_over_temp();
        @(posedge clk);
        ot <= 8'h20;
        cyc(5);
        check("heat off", out_on, 8'h85);
        @(posedge clk);
        ot <= OSF_WORD_ZERO;
        cyc(10);
        check("heat held", out_on, 8'h85);
        host_u.xfer(CMD, st);
        check("heat status", st, 8'h7A);
        cyc(2);
        check("heat rewrite", out_on, ON);
    endtask : s_over_temp

    task automatic s_over_volt();
        @(posedge clk);
        ov <= 1'b1;
        cyc(5);
        check("ov all off", out_on, OSF_WORD_ZERO);
        host_u.xfer(CMD, st);
        cyc(2);
        check("ov write", out_on, OSF_WORD_ZERO);
        @(posedge clk);
        ov <= 1'b0;
        cyc(10);
        check("ov held", out_on, OSF_WORD_ZERO);
        host_u.xfer(CMD, st);
        check("ov status", st, OSF_STATUS_OV);
        cyc(2);
        check("ov rewrite", out_on, ON);
    endtask : s_over_volt

    // ---------------------------------------------------------
    // main sequence and hang guard
    // ---------------------------------------------------------
    initial
    begin
        clk   = 1'b0;
        nrst  = 1'b0;
        sld   = 1'b0;
        ov    = 1'b0;
        ot    = OSF_WORD_ZERO;
        drain = CMD;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        cyc(4);
        s_startup();
        s_open_load();
        s_short_latch();
        s_current_limit();
        s_over_temp();
        s_over_volt();
        give_verdict();
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fail_count++;
            give_verdict();
        end
    end

endmodule : octal_switch_fault_logic_tb_top
`default_nettype wire
